/* src/vhi_pkg.sv */
// package: constants and carriers for the bus host interface logic
package vhi_pkg;
  // processor register offsets (low byte of X:$FFBx)
  localparam logic [7:0] ADDR_MODCTL   = 8'hB0;
  localparam logic [7:0] ADDR_FIFORD   = 8'hB1;
  localparam logic [7:0] ADDR_HIADDR   = 8'hB2;
  localparam logic [7:0] ADDR_HIDATA   = 8'hB3;
  localparam logic [7:0] ADDR_CMDRD    = 8'hB4;
  localparam logic [7:0] ADDR_INTREQ   = 8'hB5;
  localparam logic [7:0] ADDR_WDRST    = 8'hB6;
  localparam logic [7:0] ADDR_FIFORST  = 8'hB7;
  localparam logic [7:0] ADDR_BLTSEL   = 8'hB8;
  localparam logic [7:0] ADDR_DIRSET   = 8'hB9;
  localparam logic [7:0] ADDR_DIRCLR   = 8'hBA;
  localparam logic [7:0] ADDR_STATUS   = 8'hBB;
  localparam logic [7:0] ADDR_CTRL     = 8'hBC;
  // control register bits
  localparam int CTRL_BLT   = 0;
  localparam int CTRL_MODE  = 2;
  localparam int CTRL_HOLDN = 7;
  localparam int CTRL_FRAME = 8;
  localparam int CTRL_BOOT  = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0080;
  // field positions of the modifier control register
  localparam int MC_AM_LSB = 0;
  localparam int MC_WR     = 6;
  localparam int MC_LW     = 7;
  localparam int MC_VEC_LSB = 16;
  // slave decode: extended and standard modifiers, reset address offset
  localparam logic [5:0] AM_EXT = 6'h09;
  localparam logic [5:0] AM_STD = 6'h39;
  localparam logic [31:0] RESET_OFFS = 32'h0000_0004;
  // timing
  localparam real CLK_MHZ    = 200.0;
  localparam real WD_MS      = 62.5;
  localparam real TX_MHZ     = 4.0;
  localparam int  WD_CYCLES  = int'(WD_MS * 1000.0 * CLK_MHZ);
  localparam int  TX_HALF    = int'(CLK_MHZ / TX_MHZ / 2.0);
  localparam int  RST_CYCLES = 16;
  // master bus request bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0]  dataEn;  // byte lane enables, 1 = driven
    logic [5:0]  am;
    logic        lword;
    logic        write;
  } vhi_mst_t;
endpackage : vhi_pkg

/* src/vhi_host_if.sv */
// module: processor-side bus host interface logic
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module vhi_host_if
  import vhi_pkg::*;
#(
  parameter int WD_COUNT   = vhi_pkg::WD_CYCLES, // watchdog period
  parameter int FIFO_DEPTH = 1024,               // receive FIFO entries
  parameter int FIFO_W     = 18                  // receive FIFO width
)(
  input  wire logic        sys_clk,      // system clock
  input  wire logic        rst_b,        // async reset, low
  input  wire logic [7:0]  regAddr,      // processor register address
  input  wire logic [23:0] regWdata,     // processor write data
  input  wire logic        regWr,        // write strobe
  input  wire logic        regRd,        // read strobe
  output logic      [23:0] regRdata,     // read data, next cycle
  input  wire logic        winWr,        // write to Y bus window
  input  wire logic [14:0] winAddr,      // window address A01-A15
  input  wire logic [31:0] jumperAddr,   // command address jumpers
  input  wire logic        wdEnable,     // watchdog jumper
  input  wire logic        sAs_b,        // slave address strobe
  input  wire logic        sDs_b,        // slave data strobes
  input  wire logic        sLword_b,     // slave LWORD
  input  wire logic        sWrite_b,     // slave WRITE
  input  wire logic [5:0]  sAm,          // slave modifiers
  input  wire logic [31:0] sAddr,        // slave address
  input  wire logic [31:0] sData,        // slave data
  output logic             boardSelectPulse, // command select pulse
  output logic             irqA,         // processor level A
  output logic             irqB,         // processor line B
  output logic             procReset,    // processor reset
  output logic             bootLoad,     // boot rom load request
  input  wire logic        linkBit,      // recovered serial bit
  input  wire logic        linkStrobe,   // recovered clock tick
  input  wire logic        linkFsync,    // word boundary
  output logic             fifoEmpty,    // FIFO empty
  output logic             fifoHalf,     // FIFO half full
  output logic             txClk,        // 4 MHz serial clock
  output logic             txData,       // serial data
  output logic             txFrame,      // serial frame sync
  output logic [3:0]       busReq,       // BR0-BR3
  input  wire logic [3:0]  busGrant,     // BG0-BG3
  input  wire logic [1:0]  reqLevel,     // request level select
  output logic             busBusy_b,    // bus ownership held, low
  output vhi_pkg::vhi_mst_t mst,         // master outputs
  output logic             mstDrive_b,   // latch output enable, low
  output logic             mAs_b,        // master address strobe
  output logic             mDs_b,        // master data strobes
  input  wire logic        dtack_b,      // DTACK from slave
  output logic             busIrq_b,     // bus interrupt request
  input  wire logic        iack,         // interrupt acknowledge
  output logic [7:0]       vector,       // interrupt vector
  output logic             vectorEn_b,   // vector drive, low
  output logic [15:0]      frontData,    // front panel data
  output logic             frontFrame,   // frame handshake
  input  wire logic        frontTake     // front port accepts word
);
  import vhi_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);
  // elaboration check: pointer wrap needs a power-of-two depth
  if (FIFO_W < 16 || FIFO_DEPTH < 4 || WD_COUNT < 1 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_params
    $error("vhi_host_if: unsupported parameters");
  end

  typedef enum {IDLE, REQ, STROBE, DONE} vhi_arb_t;
  vhi_arb_t   arb;
  logic [23:0] cmdLatch, modCtl;
  logic [15:0] ctrl, hiData, hiAddr;
  logic [14:0] loAddr;
  logic [23:0] loData;
  logic        pend, dirMode, bltMode, bltFirst, imgWord;
  logic [31:0] wdCnt;
  logic [4:0]  rstCnt;
  logic        slvCmd, slvRst, slvPrev;
  logic [FIFO_W-1:0] fmem [FIFO_DEPTH];
  logic [AW:0]  wPtr, rPtr;
  logic [15:0]  shReg;
  logic [4:0]   shCnt;
  logic         popCpu, popDir, popFront, dirHalf;
  logic [15:0]  dirLow;
  logic [FIFO_W-1:0] fHead;
  logic [AW:0]  level;
  assign level = wPtr - rPtr;
  assign fHead = fmem[rPtr[AW-1:0]];

  ////////////////////////////////////////////////////////////////////
  // slave decode of command and reset addresses
  assign slvCmd = !sAs_b && !sDs_b && !sLword_b && !sWrite_b
                  && (sAm == AM_EXT || sAm == AM_STD) && sAddr == jumperAddr;
  assign slvRst = !sAs_b && !sDs_b && !sWrite_b
                  && sAddr == jumperAddr + RESET_OFFS;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      slvPrev <= 1'b0;
    else
      slvPrev <= !sAs_b;
  // select pulse, command latch, level A
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      boardSelectPulse <= 1'b0;
      cmdLatch         <= 24'h000000;
      irqA             <= 1'b0;
    end
    else
    begin
      boardSelectPulse <= slvCmd && !slvPrev;
      if (boardSelectPulse)
        cmdLatch <= sData[23:0];
      if (boardSelectPulse)
        irqA <= 1'b1;
      else if (regRd && regAddr == ADDR_CMDRD)
        irqA <= 1'b0;
    end
  // processor reset from software, watchdog
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      rstCnt    <= 5'h00;
      procReset <= 1'b0;
      wdCnt     <= 32'h0000_0000;
    end
    else
    begin
      if ((slvRst && !slvPrev) || (wdEnable && wdCnt >= 32'(WD_COUNT - 1)))
        rstCnt <= 5'(RST_CYCLES);
      else if (rstCnt != 5'h00)
        rstCnt <= rstCnt - 5'h01;
      procReset <= rstCnt != 5'h00;
      if (!wdEnable || procReset || (regWr && regAddr == ADDR_WDRST))
        wdCnt <= 32'h0000_0000;
      else
        wdCnt <= wdCnt + 32'h0000_0001;
    end
  // boot load request set by processor reset, held until a control write clears CTRL_BOOT
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      bootLoad <= 1'b1;
    else
      bootLoad <= procReset || (bootLoad && !(regWr && regAddr == ADDR_CTRL))
                  || (regWr && regAddr == ADDR_CTRL && regWdata[CTRL_BOOT]);

  ////////////////////////////////////////////////////////////////////
  // receive deserialiser and FIFO
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      shReg <= 16'h0000;
      shCnt <= 5'h00;
    end
    else if (linkStrobe)
    begin
      shReg <= {shReg[14:0], linkBit};
      shCnt <= linkFsync ? 5'h01 : shCnt + 5'h01;
    end
  logic push;
  // 16-bit words: first 16 bits from the word boundary; later bits not stored until the 5-bit count wraps, then every 32 bits push again
  assign push = linkStrobe && shCnt == 5'd15 && level != (AW+1)'(FIFO_DEPTH);
  always_ff @(posedge sys_clk)
    if (push)
      fmem[wPtr[AW-1:0]] <= FIFO_W'({shReg[14:0], linkBit});
  assign popCpu   = regRd && regAddr == ADDR_FIFORD && level != '0;
  assign popDir   = dirMode && winWr && level != '0 && !popCpu;
  assign popFront = ctrl[CTRL_FRAME] && frontTake && level != '0 && !popCpu && !popDir;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      wPtr <= '0;
      rPtr <= '0;
    end
    else if (regWr && regAddr == ADDR_FIFORST)
    begin
      wPtr <= '0;
      rPtr <= '0;
    end
    else
    begin
      if (push)
        wPtr <= wPtr + 1'b1;
      if (popCpu || popDir || popFront)
        rPtr <= rPtr + 1'b1;
    end
  // flags and line B
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      fifoEmpty <= 1'b1;
      fifoHalf  <= 1'b0;
      irqB      <= 1'b0;
    end
    else
    begin
      fifoEmpty <= level == '0;
      fifoHalf  <= level >= (AW+1)'(FIFO_DEPTH / 2);
      irqB      <= level != '0 && ctrl[CTRL_MODE];
    end
  // front panel port
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      frontData  <= 16'h0000;
      frontFrame <= 1'b0;
    end
    else
    begin
      frontFrame <= ctrl[CTRL_FRAME];
      if (popFront)
        frontData <= fHead[15:0];
    end

  ////////////////////////////////////////////////////////////////////
  // processor writes: control, latches, modes
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      modCtl  <= 24'h000000;
      ctrl    <= CTRL_RESET;
      hiAddr  <= 16'h0000;
      hiData  <= 16'h0000;
      dirMode <= 1'b0;
      bltMode <= 1'b0;
    end
    else
    begin
      if (regWr)
        case (regAddr)
          ADDR_MODCTL: modCtl  <= regWdata;
          ADDR_CTRL:   ctrl    <= regWdata[15:0];
          ADDR_HIADDR: if (hiAddr != regWdata[15:0]) hiAddr <= regWdata[15:0];
          ADDR_HIDATA: hiData  <= regWdata[15:0];
          ADDR_DIRSET: dirMode <= 1'b1;
          ADDR_DIRCLR: dirMode <= 1'b0;
          ADDR_BLTSEL: bltMode <= 1'b1;
          default:     bltMode <= bltMode && ctrl[CTRL_BLT];
        endcase
      // direct mode: second FIFO word becomes the upper half
      if (popDir && dirHalf)
        hiData <= fHead[15:0];
    end
  // lower latches loaded on each window write outside direct mode, on every second FIFO pop in direct mode
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      loAddr  <= 15'h0000;
      loData  <= 24'h000000;
      dirHalf <= 1'b0;
      dirLow  <= 16'h0000;
      pend    <= 1'b0;
      imgWord <= 1'b0;
    end
    else
    begin
      if (winWr && !dirMode)
      begin
        loAddr  <= winAddr;
        loData  <= regWdata;
        imgWord <= modCtl[MC_LW] && !ctrl[CTRL_MODE];
      end
      if (popDir)
      begin
        dirHalf <= !dirHalf;
        if (!dirHalf)
          dirLow <= fHead[15:0];
        else
        begin
          loAddr  <= winAddr;
          loData  <= {8'h00, dirLow};
          imgWord <= 1'b1;
        end
      end
      if ((winWr && !dirMode) || (popDir && dirHalf))
        pend <= 1'b1;
      else if (arb == DONE)
        pend <= 1'b0;
    end

  ////////////////////////////////////////////////////////////////////
  // arbitration and master cycle
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      arb        <= IDLE;
      busReq     <= 4'h0;
      mstDrive_b <= 1'b1;
      mAs_b      <= 1'b1;
      mDs_b      <= 1'b1;
      busBusy_b  <= 1'b1;
      bltFirst   <= 1'b1;
    end
    else
      case (arb)
        IDLE:
        begin
          if (pend || !ctrl[CTRL_HOLDN])
            busReq <= 4'b0001 << reqLevel;
          if (pend && |(busGrant & busReq))
          begin
            arb        <= STROBE;
            mstDrive_b <= 1'b0;
            busBusy_b  <= 1'b0;
          end
          else if (!pend && ctrl[CTRL_HOLDN] && !(bltMode && ctrl[CTRL_BLT]))
          begin
            busReq     <= 4'h0;
            mstDrive_b <= 1'b1;
            mAs_b      <= 1'b1;
            busBusy_b  <= 1'b1;
          end
          else if (pend)
            arb <= REQ;
        end
        REQ:
          if (|(busGrant & busReq))
          begin
            arb        <= STROBE;
            mstDrive_b <= 1'b0;
            busBusy_b  <= 1'b0;
          end
        STROBE:
        begin
          mAs_b <= 1'b0;
          mDs_b <= 1'b0;
          if (!dtack_b && !mDs_b)
          begin
            arb      <= DONE;
            mAs_b    <= !(bltMode && ctrl[CTRL_BLT]);
            mDs_b    <= 1'b1;
            bltFirst <= !(bltMode && ctrl[CTRL_BLT]);
          end
        end
        DONE:
        begin
          arb <= IDLE;
          if (ctrl[CTRL_HOLDN] && !(bltMode && ctrl[CTRL_BLT]))
          begin
            busReq     <= 4'h0;
            mstDrive_b <= 1'b1;
            mAs_b      <= 1'b1;
            busBusy_b  <= 1'b1;
          end
        end
        default: arb <= IDLE;
      endcase
  // master address, data, modifiers
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      mst <= '0;
    else
    begin
      mst.addr  <= {hiAddr, loAddr, 1'b0};
      mst.data  <= {imgWord ? hiData : 16'h0000, loData[15:0]};
      mst.data[23:16] <= imgWord ? hiData[7:0] : loData[23:16];
      mst.dataEn <= imgWord ? 8'hFF : 8'h07;
      mst.am    <= modCtl[MC_AM_LSB +: 6];
      mst.write <= modCtl[MC_WR];
      mst.lword <= modCtl[MC_LW];
    end

  ////////////////////////////////////////////////////////////////////
  // bus interrupter and outbound serial transmitter
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      busIrq_b   <= 1'b1;
      vector     <= 8'h00;
      vectorEn_b <= 1'b1;
    end
    else
    begin
      if (regWr && regAddr == ADDR_INTREQ)
        busIrq_b <= 1'b0;
      else if (iack && !busIrq_b)
        busIrq_b <= 1'b1;
      vector     <= modCtl[MC_VEC_LSB +: 8];
      vectorEn_b <= !(iack && !busIrq_b);
    end
  logic [7:0]  txDiv;
  logic [23:0] txSh;
  logic [4:0]  txCnt;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      txDiv   <= 8'h00;
      txClk   <= 1'b0;
      txSh    <= 24'h000000;
      txCnt   <= 5'h00;
      txData  <= 1'b0;
      txFrame <= 1'b0;
    end
    else
    begin
      txDiv <= (txDiv == 8'(TX_HALF - 1)) ? 8'h00 : txDiv + 8'h01;
      if (txDiv == 8'(TX_HALF - 1))
      begin
        txClk <= !txClk;
        if (txClk && txCnt != 5'h00)
        begin
          txData  <= txSh[23];
          txSh    <= {txSh[22:0], 1'b0};
          txCnt   <= txCnt - 5'h01;
          txFrame <= txCnt == 5'd24;
        end
      end
      if (regWr && regAddr == ADDR_HIDATA && txCnt == 5'h00 && ctrl[CTRL_MODE])
      begin
        txSh  <= regWdata;
        txCnt <= 5'd24;
      end
    end
  // register read port
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      regRdata <= 24'h000000;
    else if (regRd)
      case (regAddr)
        ADDR_CMDRD:  regRdata <= cmdLatch;
        ADDR_FIFORD: regRdata <= 24'(fHead);
        ADDR_MODCTL: regRdata <= modCtl;
        ADDR_CTRL:   regRdata <= {8'h00, ctrl};
        ADDR_STATUS: regRdata <= {19'h0, dirMode, bltMode, !mstDrive_b,
                                  fifoHalf, fifoEmpty};
        default:     regRdata <= 24'h000000;
      endcase
    else
      regRdata <= 24'h000000;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_select_pulse_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boardSelectPulse |=> !boardSelectPulse) else $error("select pulse too long");
  a_cmd_latched: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boardSelectPulse |=> cmdLatch == $past(sData[23:0])) else $error("command lost");
  a_empty_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    push && level == '0 |=> ##1 !fifoEmpty) else $error("empty flag stuck");
  a_request_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    winWr && !dirMode && arb == IDLE |=> ##1 busReq != 4'h0) else $error("no request");
  a_drive_granted: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(mstDrive_b) |-> $past(|(busGrant & busReq))) else $error("drive without grant");
  a_strobe_dtack: assert property (@(posedge sys_clk) disable iff (!rst_b)
    arb == STROBE && !mDs_b && !dtack_b |=> mDs_b) else $error("cycle not ended");
  a_vector_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !vectorEn_b |-> vector == $past(modCtl[23:16])) else $error("bad vector");
  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    slvRst && !slvPrev |=> ##1 procReset) else $error("no reset");
endmodule : vhi_host_if

/* bench/vhi_bus_partner.sv */
// bus partner model: arbiter and acknowledging target
`timescale 1ns/10ps
module vhi_bus_partner
  import vhi_pkg::*;
(
  input  wire logic       sys_clk,  // clock
  input  wire logic       rst_b,    // reset, low
  input  wire logic [3:0] busReq,   // request levels
  input  wire logic       mAs_b,    // address strobe
  input  wire logic       mDs_b,    // data strobe
  input  wire vhi_pkg::vhi_mst_t mst, // master lines
  input  wire logic [3:0] ackDly,   // acknowledge delay
  output logic      [3:0] busGrant, // grant levels
  output logic            dtack_b,  // acknowledge, pulled up
  output vhi_pkg::vhi_mst_t cap,    // last cycle seen
  output int              nDone     // cycles acknowledged
);
  logic [3:0] waitCnt;
  //////////////////////////////////////////////////////////////////////////////
  // grant the requested level one cycle later, drop one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      busGrant <= 4'h0;
    else
      busGrant <= busReq;
  // acknowledge after ackDly cycles, released line floats high
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      dtack_b <= 1'b1;
      waitCnt <= 4'h0;
      nDone   <= 0;
      cap     <= '0;
    end
    else if (mAs_b || mDs_b)
    begin
      dtack_b <= 1'b1;
      waitCnt <= 4'h0;
    end
    else if (dtack_b && waitCnt == ackDly)
    begin
      dtack_b <= 1'b0;
      cap     <= mst;
      nDone   <= nDone + 1;
    end
    else if (dtack_b)
      waitCnt <= waitCnt + 4'h1;
endmodule : vhi_bus_partner

/* bench/vme_host_interface_logic_tb_top.sv */
// testbench for the bus host interface logic
`timescale 1ns/10ps
module vme_host_interface_logic_tb_top
  import vhi_pkg::*;
;
  localparam int          WDC = 1000;
  localparam logic [31:0] JMP = 32'h00C0_0000;
  logic        sys_clk, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, winWr = 1'b0;
  logic        wdEnable = 1'b0, sAs_b = 1'b1, sDs_b = 1'b1, sLword_b = 1'b1, sWrite_b = 1'b1;
  logic        linkBit = 1'b0, linkStrobe = 1'b0, linkFsync = 1'b0, dtack_b;
  logic        boardSelectPulse, irqA, irqB, procReset, bootLoad, fifoEmpty, fifoHalf;
  logic        busBusy_b, mstDrive_b, mAs_b, mDs_b;
  logic        iack = 1'b0, frontTake = 1'b0, frontFrame, txClk, txData, txFrame;
  logic        busIrq_b, vectorEn_b;
  logic [7:0]  vector;
  logic [15:0] frontData;
  logic [7:0]  regAddr = 8'h00;
  logic [23:0] regWdata = 24'h0, regRdata, rd, txw;
  logic [14:0] winAddr = 15'h0, wa;
  logic [31:0] sAddr = 32'h0, sData = 32'h0;
  logic [5:0]  sAm = 6'h00;
  logic [3:0]  busReq, busGrant, reqSeen, ackDly = 4'h0;
  logic [1:0]  reqLevel = 2'h0;
  vhi_mst_t    mst, cap;
  int          bad_count, cmp_count, selCnt, rstCnt, nDone, n;
  //////////////////////////////////////////////////////////////////////////////
  vhi_host_if #(.WD_COUNT(WDC)) dut (.jumperAddr(JMP), .*);
  vhi_bus_partner far (.*);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // count pulses, reset cycles, last request level
  always @(posedge sys_clk)
  begin
    if (boardSelectPulse === 1'b1) selCnt++;
    if (procReset === 1'b1) rstCnt++;
    if (busReq !== 4'h0) reqSeen = busReq;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  task automatic wr(logic [7:0] a, logic [23:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdReg(logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask : rdReg
  // slave long-word or word write, lines scrambled when released
  task automatic slv(logic [31:0] a, logic [5:0] am, logic lw_b, logic [31:0] d);
    @(posedge sys_clk);
    sAddr    <= a;
    sAm      <= am;
    sLword_b <= lw_b;
    sWrite_b <= 1'b0;
    sData    <= d;
    sAs_b    <= 1'b0;
    sDs_b    <= 1'b0;
    tick(4);
    sAs_b <= 1'b1;
    sDs_b <= 1'b1;
    sData <= ~d;
    sAddr <= ~a;
    tick(4);
  endtask : slv
  // processor write to the bus window, wait up to 200 clocks for a cycle, expect ecy cycles
  task automatic win(logic [14:0] a, logic [23:0] d, int ecy);
    int n0;
    n0 = nDone;
    @(posedge sys_clk);
    winAddr  <= a;
    regWdata <= d;
    winWr    <= 1'b1;
    @(posedge sys_clk);
    winWr <= 1'b0;
    for (int i = 0; i < 200 && nDone == n0; i++) tick(1);
    chk("bus cycles", nDone - n0, ecy);
    tick(3);
  endtask : win
  // serial word, first bit with the word boundary
  task automatic link(logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge sys_clk);
      linkBit    <= w[i];
      linkStrobe <= 1'b1;
      linkFsync  <= (i == 15);
      @(posedge sys_clk);
      linkStrobe <= 1'b0;
    end
    tick(3);
  endtask : link
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // hang guard
  initial
  begin
    tick(60000);
    bad_count++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(12);
    rst_b <= 1'b1;
    #1;
    chk("fifoEmpty", fifoEmpty, 1);
    chk("bootLoad", bootLoad, 1);
    rdReg(ADDR_CTRL);
    chk("ctrl reset", rd, CTRL_RESET);
    $display("test reset done");
    for (int k = 0; k < 3; k++)
    begin
      n = selCnt;
      slv(JMP, k == 1 ? AM_STD : AM_EXT, k == 2, 32'hA1B2C3D4 + k);
      chk("select pulse", selCnt - n, k < 2);
      if (k < 2)
      begin
        chk("irqA", irqA, 1);
        rdReg(ADDR_CMDRD);
        chk("command", rd, 24'hB2C3D4 + k);
        tick(2);
        chk("irqA clear", irqA, 0);
      end
    end
    n = rstCnt;
    slv(JMP + RESET_OFFS, AM_EXT, 1'b0, 32'h0);
    tick(20);
    chk("reset length", rstCnt - n, RST_CYCLES);
    $display("test slave done");
    wr(ADDR_MODCTL, 24'h5A00CD);
    wr(ADDR_HIADDR, 24'h00ABCD);
    wr(ADDR_CTRL, 24'h84);
    for (int l = 0; l < 4; l++)
    begin
      reqLevel <= 2'(l);
      ackDly   <= 4'(l * 4);
      wa = 15'h1234 + 15'(l);
      win(wa, 24'h123456 + 24'(l), 1);
      chk("request level", reqSeen, 4'h1 << l);
      chk("address", cap.addr, {16'hABCD, wa, 1'b0});
      chk("data", cap.data[23:0], 24'h123456 + l);
      chk("upper lane", cap.dataEn[3], 0);
      chk("modifiers", {cap.lword, cap.write, cap.am}, 8'hCD);
      chk("released", busReq, 0);
    end
    wr(ADDR_CTRL, 24'h0);
    win(15'h0010, 24'h000777, 1);
    chk("busy held", busBusy_b, 0);
    chk("request held", busReq != 4'h0, 1);
    wr(ADDR_CTRL, 24'h80);
    tick(4);
    chk("hold released", busReq, 0);
    chk("drive released", mstDrive_b, 1);
    wr(ADDR_CTRL, 24'h85);
    wr(ADDR_BLTSEL, 24'h0);
    win(15'h0030, 24'h000111, 1);
    chk("blt strobe held", mAs_b, 0);
    win(15'h0031, 24'h000222, 1);
    wr(ADDR_CTRL, 24'h84);
    tick(2);
    chk("blt end", mAs_b, 1);
    $display("test master done");
    wr(ADDR_INTREQ, 24'h0);
    tick(1);
    chk("bus irq", busIrq_b, 0);
    iack <= 1'b1;
    tick(1);
    #1;
    chk("vector on", vectorEn_b, 0);
    chk("vector", vector, 8'h5A);
    chk("irq ack", busIrq_b, 1);
    @(posedge sys_clk);
    iack <= 1'b0;
    $display("test interrupt done");
    wr(ADDR_CTRL, 24'h84);
    wr(ADDR_HIDATA, 24'hC00001);
    @(posedge txFrame);
    repeat (24) @(posedge txClk) txw = {txw[22:0], txData};
    chk("serial word", txw, 24'hC00001);
    $display("test serial done");
    link(16'h8001);
    chk("not empty", fifoEmpty, 0);
    chk("line B", irqB, 1);
    rdReg(ADDR_FIFORD);
    chk("fifo word", rd, 24'h008001);
    tick(2);
    chk("empty again", fifoEmpty, 1);
    repeat (512) link(16'hA5A5);
    chk("half full", fifoHalf, 1);
    wr(ADDR_FIFORST, 24'h0);
    tick(2);
    chk("fifo cleared", fifoEmpty, 1);
    wr(ADDR_CTRL, 24'h180);
    link(16'h1234);
    chk("front frame", frontFrame, 1);
    @(posedge sys_clk);
    frontTake <= 1'b1;
    @(posedge sys_clk);
    frontTake <= 1'b0;
    tick(1);
    chk("front data", frontData, 16'h1234);
    wr(ADDR_CTRL, 24'h80);
    link(16'h8001);
    link(16'hA5A5);
    wr(ADDR_DIRSET, 24'h0);
    win(15'h0020, 24'h0, 0);
    win(15'h0020, 24'h0, 1);
    chk("packed word", cap.data, 32'hA5A58001);
    wr(ADDR_DIRCLR, 24'h0);
    $display("test fifo done");
    wr(ADDR_WDRST, 24'h0);
    wdEnable <= 1'b1;
    n = rstCnt;
    repeat (3)
    begin
      tick(WDC / 2);
      wr(ADDR_WDRST, 24'h0);
    end
    chk("watchdog quiet", rstCnt - n, 0);
    tick(WDC + 50);
    chk("watchdog fires", rstCnt > n, 1);
    wdEnable <= 1'b0;
    $display("test watchdog done");
    final_report();
  end
endmodule : vme_host_interface_logic_tb_top
